// ==== hw/bdm_pkg.sv ====
// Constants and types for the banked data-memory address generator.
// Assumes one core clock, a synchronous active-low reset, and one
// data-memory request at a time from the execution core.

package bdm_pkg;

   // Widths of the data space
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int BANK_W = 4;
   localparam int OFFSET_W = 8;
   localparam int NUM_BANKS = 16;
   localparam int BANK_SIZE = 256;
   localparam int MEM_DEPTH = NUM_BANKS * BANK_SIZE;

   // Access Bank split and the two banks it folds onto
   localparam logic [OFFSET_W-1:0] ACCESS_SPLIT = 8'h60;
   localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;

   // Special locations inside the top bank
   localparam logic [ADDR_W-1:0] BANK_POINTER_ADDR = 12'hFE0;
   localparam logic [ADDR_W-1:0] PC_LOW_ADDR = 12'hFF9;

   // Bank pointer reset value and its unused upper nibble
   localparam logic [BANK_W-1:0] BANK_POINTER_RESET = 4'h0;
   localparam logic [BANK_W-1:0] BANK_POINTER_UPPER = 4'h0;

   // One bit per bank, set where storage exists
   localparam logic [NUM_BANKS-1:0] IMPLEMENTED_BANKS = 16'hFFFF;

   // Kinds of request from the core
   typedef enum logic [1:0] {
      KIND_BANKED = 2'b00,
      KIND_FULL = 2'b01,
      KIND_LOAD_BANK = 2'b10,
      KIND_MOVE = 2'b11
   } req_kind_type;

   // Sequencer states
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_MOVE_WRITE = 1'b1
   } seq_state_type;

endpackage : bdm_pkg

// ==== hw/data_ram.sv ====
// Byte-wide static storage for the whole data space.
// Assumes the caller gates writes to implemented banks; no reset.
`timescale 1ns/1ns

module data_ram
   import bdm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [DATA_W-1:0] rd_data
);

   // Storage array, left uninitialised on purpose
   logic [DATA_W-1:0] mem [MEM_DEPTH];

   // Write port, contents survive every reset
   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Combinational read so the top can register in one cycle
   assign rd_data = mem[rd_addr];

endmodule : data_ram

// ==== hw/banked_data_memory_addressing.sv ====
// Address generator, bank pointer and storage for the data space.
// Assumes the execution core issues one request at a time and
// waits while busy is high; status flags are formed by the core.
`timescale 1ns/1ns

module banked_data_memory_addressing
   import bdm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic [1:0] req_kind,
   input wire logic req_access_sel,
   input wire logic [OFFSET_W-1:0] req_operand,
   input wire logic [ADDR_W-1:0] req_full_addr,
   input wire logic [ADDR_W-1:0] req_dest_addr,
   input wire logic req_write,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic busy,
   output logic ack,
   output logic [DATA_W-1:0] rd_data,
   output logic [ADDR_W-1:0] eff_addr,
   output logic [DATA_W-1:0] bank_pointer,
   output logic pc_write,
   output logic [DATA_W-1:0] pc_wdata
);

   // Sequencer state
   seq_state_type state;
   // Stored pointer nibble; upper nibble is not storage
   logic [BANK_W-1:0] bank_pointer_register;
   // Destination held across a move
   logic [ADDR_W-1:0] move_dst;
   // Request accepted this cycle
   logic take;
   // Request kind as enum
   req_kind_type kind;
   // Resolved address of the incoming request
   logic [ADDR_W-1:0] cur_addr;
   // Value read at cur_addr
   logic [DATA_W-1:0] rd_value;
   // Raw storage output
   logic [DATA_W-1:0] ram_q;
   // Write port controls
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   // Write of any kind in this cycle
   logic wr_any;

   // Bank present in storage
   function automatic logic bank_ok(input logic [ADDR_W-1:0] a);
      return IMPLEMENTED_BANKS[a[ADDR_W-1 -: BANK_W]];
   endfunction : bank_ok

   // Address resolution for one request
   function automatic logic [ADDR_W-1:0] resolve(
      input req_kind_type k,
      input logic sel,
      input logic [OFFSET_W-1:0] off,
      input logic [ADDR_W-1:0] full,
      input logic [BANK_W-1:0] bp
   );
      logic [ADDR_W-1:0] r;
      r = full;
      if (k == KIND_BANKED)
      begin
         if (sel)
         begin
            r = {bp, off};
         end
         else if (off < ACCESS_SPLIT)
         begin
            r = {ACCESS_LOW_BANK, off};
         end
         else
         begin
            r = {ACCESS_HIGH_BANK, off};
         end
      end
      return r;
   endfunction : resolve

   assign kind = req_kind_type'(req_kind);
   assign take = req_valid && (state == ST_IDLE);
   // Move source comes in on req_full_addr, pointer unused
   assign cur_addr = resolve(kind, req_access_sel, req_operand, req_full_addr,
                             bank_pointer_register);

   // Read mux: pointer, storage, or zeros
   always_comb
   begin
      if (cur_addr == BANK_POINTER_ADDR)
      begin
         rd_value = {BANK_POINTER_UPPER, bank_pointer_register};
      end
      else if (bank_ok(cur_addr))
      begin
         rd_value = ram_q;
      end
      else
      begin
         rd_value = '0;
      end
   end

   // Write port: direct write, or second half of a move
   always_comb
   begin
      if (state == ST_MOVE_WRITE)
      begin
         wr_any = 1'b1;
         wr_addr = move_dst;
         wr_data = rd_data;
      end
      else
      begin
         wr_any = take && req_write && (kind == KIND_BANKED || kind == KIND_FULL);
         wr_addr = cur_addr;
         wr_data = req_wdata;
      end
      // Unimplemented banks and the pointer never reach storage
      wr_en = wr_any && bank_ok(wr_addr) && (wr_addr != BANK_POINTER_ADDR);
   end

   // Storage
   data_ram u_data_ram (
      .clk_sys(clk_sys),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rd_addr(cur_addr),
      .rd_data(ram_q)
   );

   // Sequencer: a move reads, then writes one cycle later
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         busy <= 1'b0;
         move_dst <= '0;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
            begin
               if (take && kind == KIND_MOVE)
               begin
                  state <= ST_MOVE_WRITE;
                  busy <= 1'b1;
                  move_dst <= req_dest_addr;
               end
            end
            ST_MOVE_WRITE:
            begin
               state <= ST_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end

   // Bank pointer: literal load or data write to its address
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         bank_pointer_register <= BANK_POINTER_RESET;
      end
      else if (take && kind == KIND_LOAD_BANK)
      begin
         bank_pointer_register <= req_operand[BANK_W-1:0];
      end
      else if (wr_any && wr_addr == BANK_POINTER_ADDR)
      begin
         bank_pointer_register <= wr_data[BANK_W-1:0];
      end
   end

   // Visible pointer copy, upper nibble held at zero
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         bank_pointer <= {BANK_POINTER_UPPER, BANK_POINTER_RESET};
      end
      else if (take && kind == KIND_LOAD_BANK)
      begin
         bank_pointer <= {BANK_POINTER_UPPER, req_operand[BANK_W-1:0]};
      end
      else if (wr_any && wr_addr == BANK_POINTER_ADDR)
      begin
         bank_pointer <= {BANK_POINTER_UPPER, wr_data[BANK_W-1:0]};
      end
   end

   // Completion, read data and resolved address
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         ack <= 1'b0;
         rd_data <= '0;
         eff_addr <= '0;
      end
      else if (state == ST_MOVE_WRITE)
      begin
         ack <= 1'b1;
         eff_addr <= move_dst;
      end
      else if (take)
      begin
         // Every non-move op completes, implemented bank or not
         ack <= (kind != KIND_MOVE);
         rd_data <= rd_value;
         eff_addr <= cur_addr;
      end
      else
      begin
         ack <= 1'b0;
      end
   end

   // Program counter low byte hit by a data write
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         pc_write <= 1'b0;
         pc_wdata <= '0;
      end
      else
      begin
         pc_write <= wr_any && (wr_addr == PC_LOW_ADDR);
         if (wr_any && wr_addr == PC_LOW_ADDR)
         begin
            pc_wdata <= wr_data;
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   a_bp_upper_zero: assert property (bank_pointer[7:4] == BANK_POINTER_UPPER
      && bank_pointer[3:0] == bank_pointer_register)
      else $error("bank pointer upper nibble not zero");

   a_load_bank_lit: assert property (take && kind == KIND_LOAD_BANK |=>
      bank_pointer[3:0] == $past(req_operand[3:0]) && ack)
      else $error("literal not loaded into bank pointer");

   a_bp_next_instr: assert property (take && req_write && kind == KIND_BANKED
      && cur_addr == BANK_POINTER_ADDR |=>
      bank_pointer_register == $past(req_wdata[3:0]))
      else $error("bank pointer write not effective next cycle");

   a_banked_addr_form: assert property (take && kind == KIND_BANKED && req_access_sel
      |=> eff_addr == {$past(bank_pointer_register), $past(req_operand)})
      else $error("banked address not pointer plus operand");

   a_access_low_map: assert property (take && kind == KIND_BANKED && !req_access_sel
      && req_operand < ACCESS_SPLIT |=> eff_addr == {4'h0, $past(req_operand)})
      else $error("low access offset not in bank zero");

   a_access_high_map: assert property (take && kind == KIND_BANKED && !req_access_sel
      && req_operand >= ACCESS_SPLIT |=> eff_addr == {4'hF, $past(req_operand)})
      else $error("high access offset not in bank fifteen");

   a_pc_low_write: assert property (take && req_write && kind != KIND_MOVE
      && kind != KIND_LOAD_BANK && cur_addr == PC_LOW_ADDR |=>
      pc_write && pc_wdata == $past(req_wdata))
      else $error("write to program counter byte not forwarded");

   a_move_full_addr: assert property (take && kind == KIND_MOVE |=> busy ##1
      (ack && !busy && eff_addr == $past(req_dest_addr, 2)))
      else $error("move did not finish at its full destination");

   a_ack_every_op: assert property (take && kind != KIND_MOVE |=> ack && !busy)
      else $error("access did not complete");

   a_unimpl_zero: assert property (take && !bank_ok(cur_addr)
      && cur_addr != BANK_POINTER_ADDR |=> rd_data == 8'h00)
      else $error("unimplemented location read nonzero");

   c_move_done: cover property (take && kind == KIND_MOVE ##2 ack);
   c_access_high: cover property (take && kind == KIND_BANKED && !req_access_sel
      && req_operand >= ACCESS_SPLIT);
   c_pc_write: cover property (pc_write);
   // Pointer reached through its data address
   c_bp_data_write: cover property (wr_any && wr_addr == BANK_POINTER_ADDR);
   c_load_then_use: cover property (take && kind == KIND_LOAD_BANK ##1
      take && kind == KIND_BANKED && req_access_sel);

endmodule : banked_data_memory_addressing

// ==== bench/core_model.sv ====
// Model of the execution core that issues data-memory requests.
// Assumes the address block acks every request within a few cycles.
`timescale 1ns/1ns

module core_model
(
   input wire logic clk_sys,
   input wire logic ack,
   output logic req_valid,
   output logic [1:0] req_kind,
   output logic req_access_sel,
   output logic [7:0] req_operand,
   output logic [11:0] req_full_addr,
   output logic [11:0] req_dest_addr,
   output logic req_write,
   output logic [7:0] req_wdata
);
   // Clock edges up to the ack, the taking edge counted as the first
   int lat;

   // Quiet request lines at time zero
   initial
   begin
      {req_valid, req_kind, req_access_sel, req_write} = '0;
      {req_operand, req_full_addr, req_dest_addr, req_wdata} = '0;
   end

   // One request: held through the taking edge, then the fields are scrambled
   task automatic op(input logic [1:0] k, input logic s, input logic [7:0] o,
      input logic [11:0] f, input logic [11:0] d, input logic w, input logic [7:0] wd);
      @(posedge clk_sys);
      #1;
      {req_kind, req_access_sel, req_operand, req_full_addr} = {k, s, o, f};
      {req_dest_addr, req_write, req_wdata, req_valid} = {d, w, wd, 1'b1};
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
      // Stale fields must not be relied on
      {req_operand, req_full_addr, req_dest_addr, req_wdata} = ~{o, f, d, wd};
      lat = 1;
      while (ack !== 1'b1 && lat < 8)
      begin
         @(posedge clk_sys);
         #1;
         lat++;
      end
   endtask : op
endmodule : core_model

// ==== bench/banked_data_memory_addressing_bench.sv ====
// Self-checking bench for the banked data-memory address generator.
// Assumes all sixteen banks are present and ack follows each request.
`timescale 1ns/1ns

module banked_data_memory_addressing_bench;
   import bdm_pkg::*;

   logic clk_sys, rst_n, req_valid, req_access_sel, req_write, busy, ack, pc_write;
   logic [1:0] req_kind;
   logic [7:0] req_operand, req_wdata, rd_data, bank_pointer, pc_wdata;
   logic [11:0] req_full_addr, req_dest_addr, eff_addr;
   int errors = 0;
   int num_checks = 0;

   banked_data_memory_addressing u_banked_data_memory_addressing (.clk_sys(clk_sys),
      .rst_n(rst_n), .req_valid(req_valid), .req_kind(req_kind),
      .req_access_sel(req_access_sel), .req_operand(req_operand),
      .req_full_addr(req_full_addr), .req_dest_addr(req_dest_addr),
      .req_write(req_write), .req_wdata(req_wdata), .busy(busy), .ack(ack),
      .rd_data(rd_data), .eff_addr(eff_addr), .bank_pointer(bank_pointer),
      .pc_write(pc_write), .pc_wdata(pc_wdata));

   core_model u_core_model (.clk_sys(clk_sys), .ack(ack), .req_valid(req_valid),
      .req_kind(req_kind), .req_access_sel(req_access_sel), .req_operand(req_operand),
      .req_full_addr(req_full_addr), .req_dest_addr(req_dest_addr),
      .req_write(req_write), .req_wdata(req_wdata));

   // 25 MHz core clock
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Verdict and end of run
   task automatic tally_and_finish;
      if (errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   // Reset held ten cycles, then every output checked
   task automatic do_reset;
      rst_n = 1'b0;
      repeat (10) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      chk({rd_data, bank_pointer}, 16'h0000);
      chk({busy, ack, pc_write, 1'b0, eff_addr}, 16'h0000);
      chk({8'h00, pc_wdata}, 16'h0000);
   endtask : do_reset

   // Short-address request: access map or pointer
   task automatic acc(input logic s, input logic [7:0] o, input logic w,
      input logic [7:0] wd);
      u_core_model.op(2'b00, s, o, 12'h000, 12'h000, w, wd);
      chk(16'(u_core_model.lat), 16'h0001);
   endtask : acc

   // Full 12-bit request
   task automatic fa(input logic [11:0] a, input logic w, input logic [7:0] wd);
      u_core_model.op(2'b01, 1'b1, 8'h00, a, 12'h000, w, wd);
      chk(16'(u_core_model.lat), 16'h0001);
   endtask : fa

   // Pointer load from literal; upper operand bits must not stick
   task automatic load(input logic [3:0] n);
      u_core_model.op(2'b10, 1'b1, {4'hC, n}, 12'h000, 12'h000, 1'b0, 8'h00);
      chk({8'h00, bank_pointer}, {12'h000, n});
      chk(16'(u_core_model.lat), 16'h0001);
   endtask : load

   // File-to-file move, two cycles to ack
   task automatic mv(input logic [11:0] s, input logic [11:0] d);
      u_core_model.op(2'b11, 1'b1, 8'h00, s, d, 1'b0, 8'h00);
      chk(16'(u_core_model.lat), 16'h0002);
      chk({4'h0, eff_addr}, {4'h0, d});
      chk({14'h0000, busy, ack}, 16'h0001);
   endtask : mv

   // Hang guard at 5000 cycles, far beyond the expected 150 or so cycles
   initial
   begin
      #(40 * 5000);
      errors++;
      tally_and_finish();
   end

   // Main sequence
   initial
   begin
      do_reset();
      load(4'h3);
      acc(1'b1, 8'h25, 1'b1, 8'h5A);
      chk({4'h0, eff_addr}, 16'h0325);
      acc(1'b0, 8'h5F, 1'b1, 8'h11);
      chk({4'h0, eff_addr}, 16'h005F);
      acc(1'b0, 8'h60, 1'b1, 8'h22);
      chk({4'h0, eff_addr}, 16'h0F60);
      fa(12'h05F, 1'b0, 8'h00);
      chk({8'h00, rd_data}, 16'h0011);
      fa(12'hF60, 1'b0, 8'h00);
      chk({8'h00, rd_data}, 16'h0022);
      // One byte in every bank, read back through the pointer
      for (int b = 0; b < 16; b++)
         fa({b[3:0], 8'hA7}, 1'b1, 8'h30 + 8'(b));
      for (int b = 0; b < 16; b++)
      begin
         load(b[3:0]);
         acc(1'b1, 8'hA7, 1'b0, 8'h00);
         chk({8'h00, rd_data}, 16'h0030 + 16'(b));
         chk({4'h0, eff_addr}, {4'h0, b[3:0], 8'hA7});
      end
      // Pointer through its own address: upper nibble read as zero
      fa(BANK_POINTER_ADDR, 1'b1, 8'hF5);
      chk({8'h00, bank_pointer}, 16'h0005);
      fa(BANK_POINTER_ADDR, 1'b0, 8'h00);
      chk({8'h00, rd_data}, 16'h0005);
      // Access-mapped write to the pointer, used by the very next op
      acc(1'b0, 8'hE0, 1'b1, 8'hAF);
      chk({8'h00, bank_pointer}, 16'h000F);
      // Banked write onto the program counter byte
      acc(1'b1, 8'hF9, 1'b1, 8'h77);
      chk({7'h00, pc_write, pc_wdata}, 16'h0177);
      // Moves ignore the pointer, which still selects bank F
      mv(12'h325, 12'h1C4);
      chk({8'h00, rd_data}, 16'h005A);
      chk({8'h00, bank_pointer}, 16'h000F);
      chk({15'h0000, pc_write}, 16'h0000);
      mv(12'h325, PC_LOW_ADDR);
      chk({7'h00, pc_write, pc_wdata}, 16'h015A);
      load(4'h0);
      acc(1'b0, 8'h5F, 1'b0, 8'h00);
      chk({8'h00, rd_data}, 16'h0011);
      // Storage survives a second reset
      do_reset();
      fa(12'h1C4, 1'b0, 8'h00);
      chk({8'h00, rd_data}, 16'h005A);
      tally_and_finish();
   end
endmodule : banked_data_memory_addressing_bench
